/* rtl/gpib_ctl_pkg.sv */
// Constants, command codes and state types for the instrument bus controller
package gpib_ctl_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int IFC_HOLD_US = 100;
  localparam logic [11:0] IFC_HOLD_CYC = 12'((IFC_HOLD_US * 1000) / CLK_PERIOD_NS);
  localparam logic [3:0] MAX_LISTENERS = 4'hE;
  localparam logic [7:0] BYTE_UNL = 8'h3F;
  localparam logic [7:0] BYTE_UNT = 8'h5F;
  localparam logic [7:0] BYTE_SPE = 8'h18;
  localparam logic [7:0] BYTE_SPD = 8'h19;
  localparam logic [7:0] LAD_BASE = 8'h20;
  localparam logic [7:0] TAD_BASE = 8'h40;
  localparam logic [7:0] GROUP_MASK = 8'hE0;
  localparam logic [7:0] LINES_IDLE = 8'hFF;
  localparam int RQS_BIT = 6;
  localparam logic [4:0] LAST_ADDR = 5'h1E;
  localparam logic [2:0] STEP_UNL = 3'h0;
  localparam logic [2:0] STEP_SPE = 3'h1;
  localparam logic [2:0] STEP_TAD = 3'h2;
  localparam logic [2:0] STEP_SPD = 3'h3;
  localparam logic [2:0] STEP_UNT = 3'h4;
  localparam logic [2:0] CMD_IFC = 3'h0;
  localparam logic [2:0] CMD_ATN_BYTE = 3'h1;
  localparam logic [2:0] CMD_TALK_BYTE = 3'h2;
  localparam logic [2:0] CMD_LISTEN = 3'h3;
  localparam logic [2:0] CMD_LISTEN_STOP = 3'h4;

  typedef enum logic [1:0] {SRC_IDLE, SRC_SETUP, SRC_VALID} src_state_type;
  typedef enum logic [3:0] {
    CTL_IDLE, CTL_IFC, CTL_SEND, CTL_L_READY, CTL_L_ACK, CTL_L_WAIT, CTL_P_CMD, CTL_P_CMDW
  } ctl_state_type;
endpackage : gpib_ctl_pkg

/* rtl/gpib_source_hs.sv */
// Source handshake: drives one byte with data valid, paced by the listeners
`timescale 1ns/1ps
module gpib_source_hs
  import gpib_ctl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] byte_i,
  input wire logic eoi_i,
  input wire logic nrfd_i,
  input wire logic ndac_i,
  output logic done_o,
  output logic low_o,
  output logic [7:0] dio_oe_n_o,
  output logic dav_oe_n_o,
  output logic eoi_oe_n_o
);
  typedef struct packed {
    src_state_type st;
    logic [7:0] dio_n;
    logic dav_n;
    logic eoi_n;
    logic done;
    logic low;
  } src_type;

  src_type s_reg;
  src_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      SRC_IDLE: begin
        if (start_i) begin
          s_next.dio_n = ~byte_i;
          s_next.eoi_n = ~eoi_i;
          s_next.st = SRC_SETUP;
        end
      end
      SRC_SETUP: begin
        // Data settles one cycle; all listeners ready and none accepted yet
        if (!nrfd_i && ndac_i) begin
          s_next.dav_n = 1'b0;
          s_next.st = SRC_VALID;
        end
      end
      SRC_VALID: begin
        if (!ndac_i) begin
          s_next.dav_n = 1'b1;
          s_next.dio_n = LINES_IDLE;
          s_next.eoi_n = 1'b1;
          s_next.done = 1'b1;
          s_next.st = SRC_IDLE;
        end
      end
      default: s_next.st = SRC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= SRC_IDLE;
      s_reg.dio_n <= LINES_IDLE;
      s_reg.dav_n <= 1'b1;
      s_reg.eoi_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done_o = s_reg.done;
  assign low_o = s_reg.low;
  assign dio_oe_n_o = s_reg.dio_n;
  assign dav_oe_n_o = s_reg.dav_n;
  assign eoi_oe_n_o = s_reg.eoi_n;

  property p_no_dav_while_nrfd;
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(dav_oe_n_o) |-> $past(!nrfd_i);
  endproperty
  a_no_dav_while_nrfd: assert property (p_no_dav_while_nrfd)
    else $error("data valid asserted while a listener was not ready");

  property p_release_after_accept;
    @(posedge clk_sys_i) disable iff (rst_i)
    (!dav_oe_n_o && !ndac_i) |=> (dav_oe_n_o && dio_oe_n_o == LINES_IDLE && done_o);
  endproperty
  a_release_after_accept: assert property (p_release_after_accept)
    else $error("byte not removed after all listeners accepted");
endmodule : gpib_source_hs

/* rtl/gpib_system_controller.sv */
// Instrument bus system controller with talker and listener
`timescale 1ns/1ps
module gpib_system_controller
  import gpib_ctl_pkg::*;
#(
  parameter logic [4:0] OWN_ADDR = 5'h00
)(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic prog_running_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_code_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_eoi_i,
  input wire logic [7:0] dio_n_i,
  input wire logic dav_n_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  input wire logic eoi_n_i,
  input wire logic srq_n_i,
  output logic [7:0] dio_o,
  output logic [7:0] dio_oe_n_o,
  output logic dav_o,
  output logic dav_oe_n_o,
  output logic eoi_o,
  output logic eoi_oe_n_o,
  output logic nrfd_o,
  output logic nrfd_oe_n_o,
  output logic ndac_o,
  output logic ndac_oe_n_o,
  output logic atn_n_o,
  output logic ifc_n_o,
  output logic ren_n_o,
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic srq_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_eoi_o,
  output logic poll_done_o,
  output logic poll_found_o,
  output logic [4:0] poll_addr_o,
  output logic [7:0] poll_status_o
);
  typedef struct packed {
    ctl_state_type st;
    logic [7:0] tx;
    logic tx_eoi;
    logic start;
    logic atn_n;
    logic ifc_n;
    logic ren_n;
    logic nrfd_n;
    logic ndac_n;
    logic [7:0] rx;
    logic rx_eoi;
    logic rx_valid;
    logic done;
    logic busy;
    logic err;
    logic srq;
    logic polling;
    logic [2:0] step;
    logic [4:0] cand;
    logic poll_done;
    logic poll_found;
    logic [4:0] poll_addr;
    logic [7:0] poll_status;
    logic [3:0] lcnt;
    logic [11:0] cnt;
  } ctl_type;

  ctl_type c_reg;
  ctl_type c_next;
  logic src_done;
  logic src_low;
  logic dav_a;
  logic nrfd_a;
  logic ndac_a;
  logic srq_a;
  logic lad_cmd;

  // Bus lines are active low; internal terms are asserted-high
  assign dav_a = ~dav_n_i;
  assign nrfd_a = ~nrfd_n_i;
  assign ndac_a = ~ndac_n_i;
  assign srq_a = ~srq_n_i;
  assign lad_cmd = ((cmd_byte_i & GROUP_MASK) == LAD_BASE) && (cmd_byte_i != BYTE_UNL);

  function automatic logic [7:0] poll_byte(input logic [2:0] step, input logic [4:0] cand);
    case (step)
      STEP_UNL: poll_byte = BYTE_UNL;
      STEP_SPE: poll_byte = BYTE_SPE;
      STEP_TAD: poll_byte = TAD_BASE | {3'b000, cand};
      STEP_SPD: poll_byte = BYTE_SPD;
      default: poll_byte = BYTE_UNT;
    endcase
  endfunction : poll_byte

  gpib_source_hs u_source (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(c_reg.start),
    .byte_i(c_reg.tx),
    .eoi_i(c_reg.tx_eoi),
    .nrfd_i(nrfd_a),
    .ndac_i(ndac_a),
    .done_o(src_done),
    .low_o(src_low),
    .dio_oe_n_o(dio_oe_n_o),
    .dav_oe_n_o(dav_oe_n_o),
    .eoi_oe_n_o(eoi_oe_n_o)
  );

  always_comb begin
    logic [4:0] nc;
    nc = c_reg.cand + 5'h01;
    if (nc == OWN_ADDR) begin
      nc = nc + 5'h01;
    end
    c_next = c_reg;
    c_next.start = 1'b0;
    c_next.done = 1'b0;
    c_next.err = 1'b0;
    c_next.rx_valid = 1'b0;
    c_next.poll_done = 1'b0;
    c_next.ren_n = ~prog_running_i;
    c_next.srq = srq_a;
    case (c_reg.st)
      CTL_IDLE: begin
        if (cmd_valid_i) begin
          case (cmd_code_i)
            CMD_IFC: begin
              c_next.ifc_n = 1'b0;
              c_next.atn_n = 1'b1;
              c_next.lcnt = 4'h0;
              c_next.cnt = 12'h000;
              c_next.st = CTL_IFC;
            end
            CMD_ATN_BYTE: begin
              if (lad_cmd && c_reg.lcnt == MAX_LISTENERS) begin
                c_next.err = 1'b1;
              end else begin
                c_next.atn_n = 1'b0;
                c_next.tx = cmd_byte_i;
                c_next.tx_eoi = 1'b0;
                c_next.start = 1'b1;
                c_next.st = CTL_SEND;
                if (cmd_byte_i == BYTE_UNL) begin
                  c_next.lcnt = 4'h0;
                end else if (lad_cmd) begin
                  c_next.lcnt = c_reg.lcnt + 4'h1;
                end
              end
            end
            CMD_TALK_BYTE: begin
              c_next.atn_n = 1'b1;
              c_next.tx = cmd_byte_i;
              c_next.tx_eoi = cmd_eoi_i;
              c_next.start = 1'b1;
              c_next.st = CTL_SEND;
            end
            CMD_LISTEN: begin
              c_next.atn_n = 1'b1;
              c_next.polling = 1'b0;
              c_next.nrfd_n = 1'b0;
              c_next.ndac_n = 1'b0;
              c_next.st = CTL_L_READY;
            end
            default: c_next.err = 1'b1;
          endcase
        end else if (srq_a) begin
          c_next.polling = 1'b1;
          c_next.step = STEP_UNL;
          c_next.cand = (OWN_ADDR == 5'h00) ? 5'h01 : 5'h00;
          c_next.st = CTL_P_CMD;
        end
      end
      CTL_IFC: begin
        c_next.cnt = c_reg.cnt + 12'h001;
        if (c_reg.cnt == IFC_HOLD_CYC - 12'h001) begin
          c_next.ifc_n = 1'b1;
          c_next.done = 1'b1;
          c_next.st = CTL_IDLE;
        end
      end
      CTL_SEND: begin
        if (src_done) begin
          c_next.done = 1'b1;
          c_next.st = CTL_IDLE;
        end
      end
      CTL_L_READY: begin
        // Bus commands are never decoded here: clear, trigger and control
        // transfer from others have no effect, and ATN is ours alone
        c_next.nrfd_n = 1'b1;
        if (!c_reg.polling && cmd_valid_i && cmd_code_i == CMD_LISTEN_STOP) begin
          c_next.ndac_n = 1'b1;
          c_next.done = 1'b1;
          c_next.st = CTL_IDLE;
        end else if (dav_a) begin
          c_next.rx = ~dio_n_i;
          c_next.rx_eoi = ~eoi_n_i;
          c_next.nrfd_n = 1'b0;
          c_next.st = CTL_L_ACK;
        end
      end
      CTL_L_ACK: begin
        c_next.ndac_n = 1'b1;
        c_next.rx_valid = ~c_reg.polling;
        c_next.st = CTL_L_WAIT;
      end
      CTL_L_WAIT: begin
        if (!dav_a) begin
          c_next.ndac_n = 1'b0;
          if (c_reg.polling) begin
            c_next.poll_status = c_reg.rx;
            c_next.nrfd_n = 1'b1;
            c_next.ndac_n = 1'b1;
            c_next.step = STEP_SPD;
            c_next.st = CTL_P_CMD;
          end else if (c_reg.rx_eoi) begin
            c_next.nrfd_n = 1'b1;
            c_next.ndac_n = 1'b1;
            c_next.done = 1'b1;
            c_next.st = CTL_IDLE;
          end else begin
            c_next.st = CTL_L_READY;
          end
        end
      end
      CTL_P_CMD: begin
        c_next.atn_n = 1'b0;
        c_next.tx = poll_byte(c_reg.step, c_reg.cand);
        c_next.tx_eoi = 1'b0;
        c_next.start = 1'b1;
        c_next.st = CTL_P_CMDW;
      end
      CTL_P_CMDW: begin
        if (src_done) begin
          c_next.step = c_reg.step + 3'h1;
          c_next.st = CTL_P_CMD;
          if (c_reg.step == STEP_UNL) begin
            c_next.lcnt = 4'h0;
          end else if (c_reg.step == STEP_TAD) begin
            // Status byte is read with ATN released
            c_next.atn_n = 1'b1;
            c_next.nrfd_n = 1'b0;
            c_next.ndac_n = 1'b0;
            c_next.st = CTL_L_READY;
          end else if (c_reg.step == STEP_UNT) begin
            if (c_reg.poll_status[RQS_BIT] || nc > LAST_ADDR) begin
              c_next.atn_n = 1'b1;
              c_next.polling = 1'b0;
              c_next.poll_done = 1'b1;
              c_next.poll_found = c_reg.poll_status[RQS_BIT];
              c_next.poll_addr = c_reg.cand;
              c_next.st = CTL_IDLE;
            end else begin
              c_next.cand = nc;
              c_next.step = STEP_UNL;
            end
          end
        end
      end
      default: c_next.st = CTL_IDLE;
    endcase
    c_next.busy = (c_next.st != CTL_IDLE);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      c_reg <= '0;
      c_reg.st <= CTL_IDLE;
      c_reg.atn_n <= 1'b1;
      c_reg.ifc_n <= 1'b1;
      c_reg.ren_n <= 1'b1;
      c_reg.nrfd_n <= 1'b1;
      c_reg.ndac_n <= 1'b1;
    end else begin
      c_reg <= c_next;
    end
  end

  // Open-collector lines only ever pull low
  assign dio_o = {8{src_low}};
  assign dav_o = src_low;
  assign eoi_o = src_low;
  assign nrfd_o = src_low;
  assign ndac_o = src_low;
  assign nrfd_oe_n_o = c_reg.nrfd_n;
  assign ndac_oe_n_o = c_reg.ndac_n;
  assign atn_n_o = c_reg.atn_n;
  assign ifc_n_o = c_reg.ifc_n;
  assign ren_n_o = c_reg.ren_n;
  assign busy_o = c_reg.busy;
  assign done_o = c_reg.done;
  assign err_o = c_reg.err;
  assign srq_o = c_reg.srq;
  assign rx_valid_o = c_reg.rx_valid;
  assign rx_byte_o = c_reg.rx;
  assign rx_eoi_o = c_reg.rx_eoi;
  assign poll_done_o = c_reg.poll_done;
  assign poll_found_o = c_reg.poll_found;
  assign poll_addr_o = c_reg.poll_addr;
  assign poll_status_o = c_reg.poll_status;

  property p_ren_follows_prog;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(prog_running_i) |=> !ren_n_o;
  endproperty
  a_ren_follows_prog: assert property (p_ren_follows_prog)
    else $error("remote enable not asserted while program runs");

  property p_ifc_held;
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(ifc_n_o) |-> (!ifc_n_o && busy_o)[*8];
  endproperty
  a_ifc_held: assert property (p_ifc_held)
    else $error("interface clear released too early");

  property p_drive_only_as_source;
    @(posedge clk_sys_i) disable iff (rst_i)
    (dio_oe_n_o != LINES_IDLE) |-> (c_reg.st == CTL_SEND || c_reg.st == CTL_P_CMDW);
  endproperty
  a_drive_only_as_source: assert property (p_drive_only_as_source)
    else $error("data lines driven outside a source transfer");

  property p_srq_starts_poll;
    @(posedge clk_sys_i) disable iff (rst_i)
    (c_reg.st == CTL_IDLE && !cmd_valid_i && srq_a) |=> ##1 !atn_n_o;
  endproperty
  a_srq_starts_poll: assert property (p_srq_starts_poll)
    else $error("service request did not start a serial poll");

  property p_poll_read_atn_off;
    @(posedge clk_sys_i) disable iff (rst_i)
    (c_reg.st == CTL_L_READY) |-> atn_n_o;
  endproperty
  a_poll_read_atn_off: assert property (p_poll_read_atn_off)
    else $error("status byte read with attention asserted");

  property p_eoi_ends_listen;
    @(posedge clk_sys_i) disable iff (rst_i)
    (c_reg.st == CTL_L_WAIT && !dav_a && c_reg.rx_eoi && !c_reg.polling)
      |=> (!busy_o && done_o && nrfd_oe_n_o && ndac_oe_n_o);
  endproperty
  a_eoi_ends_listen: assert property (p_eoi_ends_listen)
    else $error("listen not ended by final byte");

  property p_listen_stop;
    @(posedge clk_sys_i) disable iff (rst_i)
    (c_reg.st == CTL_L_READY && !c_reg.polling && cmd_valid_i
      && cmd_code_i == CMD_LISTEN_STOP) |=> (nrfd_oe_n_o && ndac_oe_n_o && !busy_o);
  endproperty
  a_listen_stop: assert property (p_listen_stop)
    else $error("listener did not withdraw");

  property p_listener_limit;
    @(posedge clk_sys_i) disable iff (rst_i)
    (c_reg.lcnt == MAX_LISTENERS && c_reg.st == CTL_IDLE && cmd_valid_i
      && cmd_code_i == CMD_ATN_BYTE && lad_cmd) |=> (err_o && !busy_o);
  endproperty
  a_listener_limit: assert property (p_listener_limit)
    else $error("fifteenth listener address accepted");

  property p_atn_with_command;
    @(posedge clk_sys_i) disable iff (rst_i)
    (c_reg.st == CTL_IDLE && cmd_valid_i && cmd_code_i == CMD_ATN_BYTE && !lad_cmd)
      |=> (!atn_n_o && busy_o) ##1 (dio_oe_n_o == ~$past(cmd_byte_i, 2));
  endproperty
  a_atn_with_command: assert property (p_atn_with_command)
    else $error("command byte not sent under attention");
endmodule : gpib_system_controller

/* tb/gpib_instr_model.sv */
// Behavioural instrument on the far side of the bus: acceptor, talker, requester
`timescale 1ns/1ps
module gpib_instr_model
  import gpib_ctl_pkg::*;
#(
  parameter logic [4:0] MY_ADDR = 5'h01
)(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic atn_n_i,
  input wire logic dav_n_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  input wire logic [7:0] dio_n_i,
  input wire logic [3:0] delay_i,
  input wire logic src_go_i,
  input wire logic [7:0] src_byte_i,
  input wire logic src_eoi_i,
  input wire logic srq_req_i,
  output logic [7:0] dio_oe_n_o,
  output logic dav_oe_n_o,
  output logic eoi_oe_n_o,
  output logic nrfd_oe_n_o,
  output logic ndac_oe_n_o,
  output logic srq_oe_n_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o
);
  logic lsn, tlk, spe, pend, srq, acc;
  logic [2:0] ast;
  logic [1:0] sst;
  logic [3:0] cnt;
  logic [7:0] b;
  assign b = ~dio_n_i;
  // Idle unless addressed to listen and not to talk, or attention is asserted
  assign acc = !atn_n_i || (lsn && !tlk);
  assign srq_oe_n_o = !srq;
  always_ff @(posedge clk_sys_i) begin
    rx_valid_o <= 1'b0;
    if (rst_i) begin
      {lsn, tlk, spe, pend, srq} <= 5'h00;
      ast <= 3'h0;
      sst <= 2'h0;
      cnt <= 4'h0;
      {nrfd_oe_n_o, ndac_oe_n_o, dav_oe_n_o, eoi_oe_n_o} <= 4'hF;
      dio_oe_n_o <= 8'hFF;
    end else begin
      if (srq_req_i) srq <= 1'b1;
      if (src_go_i) pend <= 1'b1;
      if (!acc) begin
        {nrfd_oe_n_o, ndac_oe_n_o} <= 2'h3;
        ast <= 3'h0;
      end else begin
        case (ast)
          3'h0: begin
            {nrfd_oe_n_o, ndac_oe_n_o} <= 2'h0;
            cnt <= delay_i;
            ast <= 3'h1;
          end
          3'h1: begin
            if (cnt != 4'h0) cnt <= cnt - 4'h1;
            else begin
              nrfd_oe_n_o <= 1'b1;
              ast <= 3'h2;
            end
          end
          3'h2: begin
            if (!dav_n_i) begin
              nrfd_oe_n_o <= 1'b0;
              cnt <= delay_i;
              ast <= 3'h3;
              if (!atn_n_i) begin
                if (b == BYTE_UNL) lsn <= 1'b0;
                if (b == BYTE_SPE) spe <= 1'b1;
                if (b == BYTE_SPD) spe <= 1'b0;
                if (b == (LAD_BASE | {3'h0, MY_ADDR})) lsn <= 1'b1;
                if ((b & GROUP_MASK) == TAD_BASE) tlk <= (b[4:0] == MY_ADDR);
              end else begin
                rx_valid_o <= 1'b1;
                rx_byte_o <= b;
              end
            end
          end
          3'h3: begin
            if (cnt != 4'h0) cnt <= cnt - 4'h1;
            else begin
              ndac_oe_n_o <= 1'b1;
              ast <= 3'h4;
            end
          end
          default: begin
            if (dav_n_i) begin
              ndac_oe_n_o <= 1'b0;
              cnt <= delay_i;
              ast <= 3'h1;
            end
          end
        endcase
      end
      if (tlk && atn_n_i && (spe || pend)) begin
        case (sst)
          2'h0: begin
            if (nrfd_n_i && !ndac_n_i) begin
              dio_oe_n_o <= spe ? ~{1'b0, srq, 6'h15} : ~src_byte_i;
              eoi_oe_n_o <= !(src_eoi_i && !spe);
              sst <= 2'h1;
            end
          end
          2'h1: begin
            dav_oe_n_o <= 1'b0;
            sst <= 2'h2;
          end
          default: begin
            if (ndac_n_i) begin
              dav_oe_n_o <= 1'b1;
              dio_oe_n_o <= 8'hFF;
              eoi_oe_n_o <= 1'b1;
              sst <= 2'h0;
              if (spe) begin
                srq <= 1'b0;
                tlk <= 1'b0;
              // A new request may land on the edge that ends the last byte
              end else pend <= src_go_i;
            end
          end
        endcase
      end
    end
  end
endmodule : gpib_instr_model

/* tb/gpib_system_controller_tb.sv */
// Self-checking bench for the bus controller against one instrument model
`timescale 1ns/1ps
module gpib_system_controller_tb;
  import gpib_ctl_pkg::*;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, prog_running_i = 1'b0, cmd_valid_i = 1'b0;
  logic cmd_eoi_i = 1'b0, src_go = 1'b0, src_eoi = 1'b0, srq_req = 1'b0, d, e, seen;
  logic [2:0] cmd_code_i = 3'h0;
  logic [7:0] cmd_byte_i = 8'h00, src_byte = 8'h00, bv;
  logic [3:0] m_delay = 4'h0;
  logic [7:0] dio_n_i, dio_oe_n_o, m_dio, m_rx_byte, rx_byte_o, poll_status_o;
  logic dav_n_i, nrfd_n_i, ndac_n_i, eoi_n_i, srq_n_i, dav_oe_n_o, eoi_oe_n_o;
  logic nrfd_oe_n_o, ndac_oe_n_o, atn_n_o, ifc_n_o, ren_n_o, busy_o, done_o, err_o;
  logic srq_o, rx_valid_o, rx_eoi_o, poll_done_o, poll_found_o;
  logic m_dav, m_eoi, m_nrfd, m_ndac, m_srq, m_rx_valid;
  logic [7:0] dio_o;
  logic dav_o, eoi_o, nrfd_o, ndac_o;
  logic [4:0] poll_addr_o;
  logic [31:0] lfsr = 32'h140A3F7D;
  logic [15:0] exp_tx[$], exp_rx[$], exp_poll[$];
  int err_count = 0, checks_done = 0, cyc = 0, n;
  always #20 clk_sys_i = ~clk_sys_i;
  // Open-collector wires with pull-ups
  assign dio_n_i = dio_oe_n_o & m_dio;
  assign dav_n_i = dav_oe_n_o & m_dav;
  assign nrfd_n_i = nrfd_oe_n_o & m_nrfd;
  assign ndac_n_i = ndac_oe_n_o & m_ndac;
  assign eoi_n_i = eoi_oe_n_o & m_eoi;
  assign srq_n_i = m_srq;
  gpib_system_controller #(.OWN_ADDR(5'h00)) DUT (.clk_sys_i, .rst_i, .prog_running_i,
    .cmd_valid_i, .cmd_code_i, .cmd_byte_i, .cmd_eoi_i, .dio_n_i, .dav_n_i, .nrfd_n_i,
    .ndac_n_i, .eoi_n_i, .srq_n_i, .dio_o, .dio_oe_n_o, .dav_o, .dav_oe_n_o, .eoi_o,
    .eoi_oe_n_o, .nrfd_o, .nrfd_oe_n_o, .ndac_o, .ndac_oe_n_o, .atn_n_o, .ifc_n_o,
    .ren_n_o, .busy_o, .done_o, .err_o, .srq_o, .rx_valid_o, .rx_byte_o, .rx_eoi_o,
    .poll_done_o, .poll_found_o, .poll_addr_o, .poll_status_o);
  gpib_instr_model #(.MY_ADDR(5'h01)) partner (.clk_sys_i, .rst_i, .atn_n_i(atn_n_o),
    .dav_n_i, .nrfd_n_i, .ndac_n_i, .dio_n_i, .delay_i(m_delay), .src_go_i(src_go),
    .src_byte_i(src_byte), .src_eoi_i(src_eoi), .srq_req_i(srq_req), .dio_oe_n_o(m_dio),
    .dav_oe_n_o(m_dav), .eoi_oe_n_o(m_eoi), .nrfd_oe_n_o(m_nrfd), .ndac_oe_n_o(m_ndac),
    .srq_oe_n_o(m_srq), .rx_valid_o(m_rx_valid), .rx_byte_o(m_rx_byte));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic issue(input logic [2:0] code, input logic [7:0] byt, input logic eoi);
    tick();
    {cmd_valid_i, cmd_code_i, cmd_byte_i, cmd_eoi_i} = {1'b1, code, byt, eoi};
    m_delay = {1'b0, lfsr[2:0]};
    lfsr = lfsr_next(lfsr);
    tick();
    cmd_valid_i = 1'b0;
  endtask : issue
  task automatic finish(output logic got_done, output logic got_err, output int low);
    {got_done, got_err, low} = '0;
    for (int i = 0; i < 4000 && !got_done && !got_err; i++) begin
      if (ifc_n_o === 1'b0) low++;
      got_done = (done_o === 1'b1);
      got_err = (err_o === 1'b1);
      if (!got_done && !got_err) tick();
    end
  endtask : finish
  task automatic send(input logic [2:0] code, input logic [7:0] byt, input logic eoi,
                      input logic bad);
    issue(code, byt, eoi);
    finish(d, e, n);
    check_val("cmd_done", {15'h0, !bad}, {15'h0, d});
    check_val("cmd_err", {15'h0, bad}, {15'h0, e});
  endtask : send
  // Result watcher: oldest note against each result as it appears
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
    // End marker is still driven here: the talker holds it until all accept
    if (m_rx_valid === 1'b1)
      check_val("tx_byte", exp_tx.size() ? exp_tx.pop_front() : 16'hFFFF,
                {7'h0, ~eoi_n_i, m_rx_byte});
    if (rx_valid_o === 1'b1)
      check_val("rx_byte", exp_rx.size() ? exp_rx.pop_front() : 16'hFFFF,
                {7'h0, rx_eoi_o, rx_byte_o});
    if (poll_done_o === 1'b1)
      check_val("poll", exp_poll.size() ? exp_poll.pop_front() : 16'hFFFF,
                {2'h0, poll_found_o, poll_addr_o, poll_status_o});
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    check_val("ren_n", 16'h1, {15'h0, ren_n_o});
    check_val("ifc_n", 16'h1, {15'h0, ifc_n_o});
    prog_running_i = 1'b1;
    repeat (2) tick();
    check_val("ren_n", 16'h0, {15'h0, ren_n_o});
    issue(CMD_IFC, 8'h00, 1'b0);
    finish(d, e, n);
    check_val("ifc_len", 16'(IFC_HOLD_CYC), 16'(n));
    check_val("ifc_done", 16'h1, {15'h0, d});
    send(CMD_ATN_BYTE, BYTE_UNL, 1'b0, 1'b0);
    send(CMD_ATN_BYTE, LAD_BASE | 8'h01, 1'b0, 1'b0);
    check_val("atn_n", 16'h0, {15'h0, atn_n_o});
    for (int k = 0; k < 4; k++) begin
      bv = lfsr[7:0];
      exp_tx.push_back({7'h0, k == 3, bv});
      send(CMD_TALK_BYTE, bv, k == 3, 1'b0);
    end
    check_val("atn_n", 16'h1, {15'h0, atn_n_o});
    send(CMD_ATN_BYTE, BYTE_UNL, 1'b0, 1'b0);
    for (int i = 0; i < 15; i++) send(CMD_ATN_BYTE, LAD_BASE + 8'(i + 2), 1'b0, i == 14);
    send(CMD_ATN_BYTE, BYTE_UNL, 1'b0, 1'b0);
    send(CMD_ATN_BYTE, LAD_BASE | 8'h02, 1'b0, 1'b0);
    send(CMD_LISTEN_STOP, 8'h00, 1'b0, 1'b1);
    for (int c = 5; c < 8; c++) send(3'(c), 8'h00, 1'b0, 1'b1);
    send(CMD_ATN_BYTE, BYTE_UNL, 1'b0, 1'b0);
    send(CMD_ATN_BYTE, TAD_BASE | 8'h01, 1'b0, 1'b0);
    issue(CMD_LISTEN, 8'h00, 1'b0);
    for (int k = 0; k < 3; k++) begin
      {src_byte, src_eoi, src_go} = {lfsr[15:8], k == 2, 1'b1};
      lfsr = lfsr_next(lfsr);
      exp_rx.push_back({7'h0, src_eoi, src_byte});
      tick();
      src_go = 1'b0;
      for (int i = 0; i < 300 && k < 2 && rx_valid_o !== 1'b1; i++) tick();
    end
    finish(d, e, n);
    check_val("listen_end", 16'h1, {15'h0, d});
    issue(CMD_LISTEN, 8'h00, 1'b0);
    repeat (4) tick();
    send(CMD_LISTEN_STOP, 8'h00, 1'b0, 1'b0);
    send(CMD_ATN_BYTE, 8'h14, 1'b0, 1'b0);
    send(CMD_ATN_BYTE, 8'h08, 1'b0, 1'b0);
    check_val("busy", 16'h0, {15'h0, busy_o});
    exp_poll.push_back({2'h0, 1'b1, 5'h01, 8'h55});
    tick();
    srq_req = 1'b1;
    tick();
    srq_req = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 3000 && poll_done_o !== 1'b1; i++) begin
      seen = seen | (srq_o === 1'b1);
      tick();
    end
    check_val("srq_seen", 16'h1, {15'h0, seen});
    check_val("poll_done", 16'h1, {15'h0, poll_done_o});
    check_val("atn_n", 16'h1, {15'h0, atn_n_o});
    repeat (4) tick();
    check_val("srq_o", 16'h0, {15'h0, srq_o});
    check_val("ren_n", 16'h0, {15'h0, ren_n_o});
    check_val("oc_level", 16'h0, {4'h0, dio_o, dav_o, eoi_o, nrfd_o, ndac_o});
    complete_run();
  end
endmodule : gpib_system_controller_tb
